/* subcode_pkg.sv */
`default_nettype none
package subcode_pkg;

  // ---------------------------------------------------------------
  // register map (indices; byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_IDX = 32'h92;
  localparam int unsigned USER1_IDX = 32'h88;
  localparam int unsigned Q1_IDX = 32'h8c;
  localparam int unsigned USER2_IDX = 32'hd8;
  localparam int unsigned Q2_IDX = 32'hdc;
  localparam logic [11:0] CTRL_ADDR = 12'(CTRL_IDX * 4);
  localparam logic [11:0] USER1_ADDR = 12'(USER1_IDX * 4);
  localparam logic [11:0] Q1_ADDR = 12'(Q1_IDX * 4);
  localparam logic [11:0] USER2_ADDR = 12'(USER2_IDX * 4);
  localparam logic [11:0] Q2_ADDR = 12'(Q2_IDX * 4);

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int unsigned LOAD_EN_BIT = 15;
  localparam int unsigned LOAD_VAL_MSB = 14;
  localparam int unsigned LOAD_VAL_LSB = 8;
  localparam int unsigned MODE1_BIT = 1;
  localparam int unsigned MODE2_BIT = 2;
  localparam int unsigned TX_TIMING_BIT = 0;

  // ---------------------------------------------------------------
  // symbol and packet figures, in user-channel bits and symbols
  // ---------------------------------------------------------------
  localparam logic [5:0] SYNC1_ZEROS = 6'h0b;  // 11 zeros: first sync
  localparam logic [5:0] SYNC2_ZEROS = 6'h17;  // 23 zeros: second sync
  localparam logic [5:0] SYNC3_ZEROS = 6'h23;  // 35 zeros: third sync
  localparam logic [5:0] ZERO_SAT = 6'h3f;
  localparam logic [2:0] SYM_LAST_BIT = 3'h7;
  localparam logic [6:0] FIRST_DATA_POS = 7'h02;
  localparam logic [6:0] LAST_POS = 7'h61;  // symbol 98 of the packet
  localparam logic [1:0] U_LAST_BYTE = 2'h3;
  localparam logic [4:0] Q_LAST_BIT = 5'h1f;
  localparam int unsigned Q_BIT_POS = 6;
  localparam logic [2:0] SYNC_PATTERN = 3'h4;  // data, sync, sync before data

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;  // one-cycle strobe, one per subframe
    logic value;  // user-channel bit
  } ubit_t;

  typedef struct packed {
    logic user_word_full;
    logic user_word_overrun;
    logic q_word_full;
    logic q_word_overrun;
    logic packet_sync_found;
    logic packet_length_error;
  } rx_event_t;

  typedef struct packed {
    logic [5:0] zero_cnt;
    logic in_sym;
    logic [2:0] bit_cnt;
    logic [7:0] sym;
    logic [2:0] hist;
    logic [6:0] pos;
    logic [31:0] u_shift;
    logic [1:0] u_cnt;
    logic [31:0] q_shift;
    logic [4:0] q_cnt;
    logic [31:0] u_word;
    logic [31:0] q_word;
    logic u_unread;
    logic q_unread;
  } chan_t;

endpackage
`default_nettype wire

/* subcode_receiver.sv */
// ---------------------------------------------------------------
// Overview of operation
// ---------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module subcode_receiver (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire subcode_pkg::ubit_t [1:0] ubit,
  output subcode_pkg::rx_event_t [1:0] rx_event,
  output logic user_tx_timing_source
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    subcode_pkg::chan_t [1:0] ch;
    subcode_pkg::rx_event_t [1:0] ev;
    logic [6:0] load_value;
    logic [1:0] cd_mode;
    logic tx_timing;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } state_t;

  state_t q, n;

  // one byte into the top-aligned shift word, earliest byte highest
  function automatic logic [31:0] push_byte(input logic [31:0] w, input logic [7:0] b);
    push_byte = {w[23:0], b};
  endfunction

  // every byte of a word carries its leading one
  function automatic logic all_msb_set(input logic [31:0] w);
    all_msb_set = w[31] & w[23] & w[15] & w[7];
  endfunction

  // each byte is a data byte with its leading one, or an all-zero sync byte
  function automatic logic bytes_ok(input logic [31:0] w);
    bytes_ok = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (!w[8*k+7] && w[8*k +: 8] != 8'h00) begin
        bytes_ok = 1'b0;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    subcode_pkg::chan_t c;
    subcode_pkg::rx_event_t e;
    logic sel;
    logic rd;
    logic load;
    logic cd;
    logic sym_done;
    logic is_data;
    logic deliver;
    logic end_pkt;
    logic [7:0] byte_v;
    c = '0;
    e = '0;
    sym_done = 1'b0;
    is_data = 1'b0;
    deliver = 1'b0;
    end_pkt = 1'b0;
    byte_v = '0;
    cd = 1'b0;
    n = q;
    load = 1'b0;
    // address phase taken on hready, zero wait states
    sel = hsel && htrans[1] && hready;
    rd = sel && !hwrite;
    n.wr_pend = sel && hwrite;
    n.wr_addr = sel ? haddr[11:0] : q.wr_addr;
    n.ready = 1'b1;
    n.resp = 1'b0;
    // write data phase into the control register
    if (q.wr_pend && q.wr_addr == subcode_pkg::CTRL_ADDR) begin
      n.load_value = hwdata[subcode_pkg::LOAD_VAL_MSB:subcode_pkg::LOAD_VAL_LSB];
      n.cd_mode = {hwdata[subcode_pkg::MODE2_BIT], hwdata[subcode_pkg::MODE1_BIT]};
      n.tx_timing = hwdata[subcode_pkg::TX_TIMING_BIT];
      load = hwdata[subcode_pkg::LOAD_EN_BIT];
    end
    // per-receiver bit and symbol processing
    for (int i = 0; i < 2; i++) begin
      c = q.ch[i];
      e = '0;
      cd = n.cd_mode[i];
      sym_done = 1'b0;
      is_data = 1'b0;
      byte_v = '0;
      deliver = 1'b0;
      end_pkt = 1'b0;
      // a read clears the unread flag; a completion below still sets it
      if (rd && haddr[11:0] == (i == 0 ? subcode_pkg::USER1_ADDR : subcode_pkg::USER2_ADDR)) begin
        c.u_unread = 1'b0;
      end
      if (rd && haddr[11:0] == (i == 0 ? subcode_pkg::Q1_ADDR : subcode_pkg::Q2_ADDR)) begin
        c.q_unread = 1'b0;
      end
      // one bit per strobe
      if (ubit[i].valid) begin
        if (c.in_sym) begin
          c.sym = {c.sym[6:0], ubit[i].value};
          if (c.bit_cnt == subcode_pkg::SYM_LAST_BIT) begin
            c.in_sym = 1'b0;
            sym_done = 1'b1;
            is_data = 1'b1;
            byte_v = c.sym;
          end
          c.bit_cnt = c.bit_cnt + 3'h1;
        end else if (ubit[i].value) begin
          // leading one starts a data symbol
          c.in_sym = 1'b1;
          c.sym = 8'h01;
          c.bit_cnt = 3'h1;
          c.zero_cnt = '0;
        end else begin
          if (c.zero_cnt != subcode_pkg::ZERO_SAT) begin
            c.zero_cnt = c.zero_cnt + 6'h01;
          end
          // in cd mode only, a sync symbol at each zero-run threshold
          if (cd && (c.zero_cnt == subcode_pkg::SYNC1_ZEROS || c.zero_cnt == subcode_pkg::SYNC2_ZEROS ||
                     c.zero_cnt == subcode_pkg::SYNC3_ZEROS)) begin
            sym_done = 1'b1;
          end
        end
      end
      if (sym_done) begin
        if (cd) begin
          // pattern resync: start of a new packet at an unexpected position
          if (is_data && c.hist == subcode_pkg::SYNC_PATTERN && c.pos != subcode_pkg::FIRST_DATA_POS) begin
            e.packet_sync_found = 1'b1;
            e.packet_length_error = 1'b1;
            c.pos = subcode_pkg::FIRST_DATA_POS;
            c.u_cnt = '0;
            c.q_cnt = '0;
          end
          c.hist = {c.hist[1:0], is_data};
          deliver = c.pos >= subcode_pkg::FIRST_DATA_POS;
          end_pkt = c.pos == subcode_pkg::LAST_POS;
        end else begin
          deliver = is_data;
        end
        if (deliver) begin
          if (!is_data) begin
            byte_v = '0;
          end
          c.u_shift = push_byte(c.u_shift, byte_v);
          if (c.u_cnt == subcode_pkg::U_LAST_BYTE) begin
            c.u_word = c.u_shift;
            e.user_word_full = 1'b1;
            e.user_word_overrun = c.u_unread;
            c.u_unread = 1'b1;
          end
          c.u_cnt = c.u_cnt + 2'h1;
          if (cd) begin
            c.q_shift = {c.q_shift[30:0], byte_v[subcode_pkg::Q_BIT_POS]};
            if (c.q_cnt == subcode_pkg::Q_LAST_BIT) begin
              c.q_word = c.q_shift;
              e.q_word_full = 1'b1;
              e.q_word_overrun = c.q_unread;
              c.q_unread = 1'b1;
            end
            c.q_cnt = c.q_cnt + 5'h01;
          end
        end
        if (cd && end_pkt) begin
          e.packet_sync_found = 1'b1;
          if (!(e.user_word_full && e.q_word_full)) begin
            e.packet_length_error = 1'b1;
          end
        end
        // free-running position, wraps on its own without a pattern
        if (cd) begin
          c.pos = end_pkt ? '0 : c.pos + 7'h01;
        end
      end
      if (load) begin
        c.pos = n.load_value;
      end
      n.ch[i] = c;
      n.ev[i] = e;
    end
    // read data captured at the address phase
    n.rdata = '0;
    if (rd) begin
      unique case (haddr[11:0])
        subcode_pkg::CTRL_ADDR: begin
          n.rdata[subcode_pkg::LOAD_VAL_MSB:subcode_pkg::LOAD_VAL_LSB] = n.load_value;
          n.rdata[subcode_pkg::MODE2_BIT] = n.cd_mode[1];
          n.rdata[subcode_pkg::MODE1_BIT] = n.cd_mode[0];
          n.rdata[subcode_pkg::TX_TIMING_BIT] = n.tx_timing;
        end
        subcode_pkg::USER1_ADDR: n.rdata = q.ch[0].u_word;
        subcode_pkg::Q1_ADDR: n.rdata = q.ch[0].q_word;
        subcode_pkg::USER2_ADDR: n.rdata = q.ch[1].u_word;
        subcode_pkg::Q2_ADDR: n.rdata = q.ch[1].q_word;
        default: n.rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.ready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // outputs straight from flops
  assign hrdata = q.rdata;
  assign hreadyout = q.ready;
  assign hresp = q.resp;
  assign rx_event = q.ev;
  assign user_tx_timing_source = q.tx_timing;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic ctrl_wr;
  assign ctrl_wr = q.wr_pend && q.wr_addr == subcode_pkg::CTRL_ADDR;

  a_preset_load: assert property (ctrl_wr && hwdata[15] |=> q.ch[0].pos == $past(hwdata[14:8]))
    else $error("sync counter not loaded from preset");
  a_preset_hold: assert property (ctrl_wr && !hwdata[15] && !(ubit[0].valid) |=> q.ch[0].pos == $past(q.ch[0].pos))
    else $error("sync counter moved without preset enable");
  a_ctrl_readback: assert property (
    hsel && htrans[1] && hready && !hwrite && haddr[11:0] == subcode_pkg::CTRL_ADDR
    |=> hrdata[15] == 1'b0 && hrdata[14:8] == q.load_value)
    else $error("control read back wrong");
  a_q_with_user: assert property (rx_event[0].q_word_full |-> rx_event[0].user_word_full)
    else $error("q full without user full");
  a_sync_end_words: assert property (
    rx_event[0].packet_sync_found && !rx_event[0].packet_length_error
    |-> rx_event[0].user_word_full && rx_event[0].q_word_full)
    else $error("sync found without final words");
  // the unread flag seen by the completing cycle is the one registered before it
  a_overrun_cause: assert property (
    rx_event[0].user_word_overrun |-> rx_event[0].user_word_full && $past(q.ch[0].u_unread))
    else $error("overrun without unread word");
  a_q_overrun_cause: assert property (
    rx_event[0].q_word_overrun |-> rx_event[0].q_word_full && $past(q.ch[0].q_unread))
    else $error("q overrun without unread word");
  // a length error always comes with a sync found
  a_length_with_sync: assert property (
    rx_event[0].packet_length_error |-> rx_event[0].packet_sync_found)
    else $error("length error without sync found");
  // packet events only in cd mode, per receiver
  a_q_full_cd_only: assert property (rx_event[0].q_word_full |-> q.cd_mode[0])
    else $error("q word full outside cd mode on receiver one");
  a_sync_cd_only: assert property (
    rx_event[0].packet_sync_found || rx_event[0].packet_length_error |-> q.cd_mode[0])
    else $error("packet event outside cd mode on receiver one");
  a_lane_two_mode: assert property (
    rx_event[1].q_word_full || rx_event[1].packet_sync_found |-> q.cd_mode[1])
    else $error("packet event outside cd mode on receiver two");
  // after a sync the position restarts: end of packet or first data slot just used
  a_sync_restarts: assert property (
    rx_event[0].packet_sync_found && !$past(ctrl_wr)
    |-> q.ch[0].pos == '0 || q.ch[0].pos == subcode_pkg::FIRST_DATA_POS + 7'h01)
    else $error("position not restarted at sync");
  // in cd mode a word holds only data bytes or zero sync bytes
  a_cd_bytes: assert property (
    q.cd_mode[0] && rx_event[0].user_word_full |-> bytes_ok(q.ch[0].u_word))
    else $error("cd byte neither data nor zero");

  // full events counted since the last packet sync, for the per-packet totals
  localparam logic [4:0] U_FULLS_BEFORE_END = 5'h17;  // 23 user fulls precede the final one
  localparam logic [1:0] Q_FULLS_BEFORE_END = 2'h2;  // 2 q fulls precede the final one
  logic [4:0] u_fulls_q;
  logic [1:0] q_fulls_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      u_fulls_q <= '0;
      q_fulls_q <= '0;
    end else if (rx_event[0].packet_sync_found) begin
      u_fulls_q <= '0;
      q_fulls_q <= '0;
    end else begin
      u_fulls_q <= u_fulls_q + 5'(rx_event[0].user_word_full);
      q_fulls_q <= q_fulls_q + 2'(rx_event[0].q_word_full);
    end
  end

  a_user_full_count: assert property (
    rx_event[0].packet_sync_found && !rx_event[0].packet_length_error |-> u_fulls_q == U_FULLS_BEFORE_END)
    else $error("wrong number of user fulls in packet");
  a_q_full_count: assert property (
    rx_event[0].packet_sync_found && !rx_event[0].packet_length_error |-> q_fulls_q == Q_FULLS_BEFORE_END)
    else $error("wrong number of q fulls in packet");
  a_pos_range: assert property (!$past(ctrl_wr) |-> q.ch[0].pos <= subcode_pkg::LAST_POS)
    else $error("packet position past end");
  a_plain_msb: assert property (!q.cd_mode[0] && rx_event[0].user_word_full |-> all_msb_set(q.ch[0].u_word))
    else $error("data byte without leading one");
  a_always_ready: assert property (hreadyout && !hresp)
    else $error("slave not ready or error response");

  c_sync_found: cover property (rx_event[0].packet_sync_found && !rx_event[0].packet_length_error);
  c_length_error: cover property (rx_event[0].packet_length_error);
  c_q_overrun: cover property (rx_event[0].q_word_overrun);
  c_user_overrun: cover property (rx_event[0].user_word_overrun);
  c_preset_load: cover property (ctrl_wr && hwdata[subcode_pkg::LOAD_EN_BIT]);

endmodule
`default_nettype wire

/* ubit_source.sv */
`timescale 1ns/10ps
`default_nettype none
// -------------------------------------------------------------
// user-bit front end model, same stream on both lanes
// -------------------------------------------------------------
module ubit_source (
  input wire logic hclk,
  output var subcode_pkg::ubit_t [1:0] ubit
);
  // idle lanes until the first bit
  initial begin
    ubit = '0;
  end

  // one bit per one-cycle strobe, then 0..2 idle cycles; idle value is inverted
  task automatic put(input logic b);
    int gap;
    gap = $urandom_range(2, 0);
    @(posedge hclk);
    ubit <= {2{1'b1, b}};
    repeat (gap) begin
      @(posedge hclk);
      ubit <= {2{1'b0, ~b}};
    end
  endtask

  // drop the strobe when the stream pauses
  task automatic rest();
    @(posedge hclk);
    ubit <= {2{1'b0, ~ubit[0].value}};
  endtask

  // a run of zero bits between symbols
  task automatic send_zeros(input int n);
    repeat (n) put(1'b0);
  endtask

  // one symbol, leading one first
  task automatic send_sym(input logic [7:0] s);
    for (int i = 7; i >= 0; i--) begin
      put(s[i]);
    end
  endtask
endmodule
`default_nettype wire

/* spdif_user_subcode_receiver_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module spdif_user_subcode_receiver_tb;
  logic hclk, hresetn, hsel, hwrite;
  logic dph_q = 1'b0;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] v;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, user_tx_timing_source;
  wire subcode_pkg::rx_event_t [1:0] rx_event;
  wire subcode_pkg::ubit_t [1:0] ubit;
  subcode_pkg::rx_event_t ev_q[$];
  subcode_pkg::rx_event_t ev_e;
  logic [31:0] rd_q[$];
  logic [31:0] uw = '0, qw = '0;
  int n_fail = 0, tests_run = 0, cycles = 0, uc = 0, qc = 0, dc = 0;
  bit cd = 0, u_unr = 0, q_unr = 0;

  subcode_receiver subcode_receiver_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ubit(ubit), .rx_event(rx_event),
    .user_tx_timing_source(user_tx_timing_source));
  ubit_source ubit_source_i (.hclk(hclk), .ubit(ubit));

  // -------------------------------------------------------------
  // clock, compare and close
  // -------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // note read data phases and cut a hang short
  always @(posedge hclk) begin
    dph_q <= hsel & htrans[1] & ~hwrite & hreadyout;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_fail++;
      summarize();
    end
  end

  // watcher: compare each result against the oldest note
  always @(negedge hclk) begin
    if (hresetn && dph_q) begin
      check(hrdata, rd_q.pop_front());
      check(hresp, 1'b0);
    end
    if (hresetn && rx_event !== '0) begin
      ev_e = (ev_q.size() != 0) ? ev_q.pop_front() : '0;
      check(rx_event[0], ev_e);
      check(rx_event[1], ev_e);
    end
  end

  // -------------------------------------------------------------
  // bus master and stream tasks
  // -------------------------------------------------------------
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : $urandom;
    if (!w) rd_q.push_back(d);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  // zero run, then one data symbol; notes the events it must cause
  task automatic data_sym(input int gap, input bit err);
    logic [7:0] s;
    subcode_pkg::rx_event_t e;
    s = {1'b1, 7'($urandom)};
    e = '0;
    ubit_source_i.send_zeros(gap);
    if (err) begin
      e.packet_sync_found = 1'b1;
      e.packet_length_error = 1'b1;
      uc = 0;
      qc = 0;
      dc = 0;
    end
    uw = {uw[23:0], s};
    qw = {qw[30:0], s[subcode_pkg::Q_BIT_POS]};
    uc++;
    qc++;
    dc++;
    if (uc == 4) begin
      e.user_word_full = 1'b1;
      e.user_word_overrun = u_unr;
      u_unr = 1;
      uc = 0;
    end
    if (cd && qc == 32) begin
      e.q_word_full = 1'b1;
      e.q_word_overrun = q_unr;
      q_unr = 1;
      qc = 0;
    end
    if (cd && dc == 96) begin
      e.packet_sync_found = 1'b1;
      dc = 0;
    end
    if (e !== '0) ev_q.push_back(e);
    ubit_source_i.send_sym(s);
  endtask

  // read and check the user word of both receivers, and in cd mode the q word of both too
  task automatic read_words();
    ubit_source_i.rest();
    bus(1'b0, subcode_pkg::USER1_ADDR, uw);
    bus(1'b0, subcode_pkg::USER2_ADDR, uw);
    if (cd) begin
      bus(1'b0, subcode_pkg::Q1_ADDR, qw);
      bus(1'b0, subcode_pkg::Q2_ADDR, qw);
    end
    u_unr = 0;
    q_unr = 0;
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    void'($urandom(32'h804a));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, subcode_pkg::CTRL_ADDR, 32'h0000_0000);
    bus(1'b0, 12'h100, 32'h0000_0000);
    bus(1'b1, subcode_pkg::CTRL_ADDR, 32'h0000_0001);
    bus(1'b0, subcode_pkg::CTRL_ADDR, 32'h0000_0001);
    check(user_tx_timing_source, 1'b1);
    // other-data mode: long runs carry no syncs, second word overruns
    repeat (8) data_sym($urandom_range(45, 2), 1'b0);
    read_words();
    v = 7'($urandom_range(80, 16));
    bus(1'b1, subcode_pkg::CTRL_ADDR, {16'h0, 1'b1, v, 8'h06});
    bus(1'b0, subcode_pkg::CTRL_ADDR, {16'h0, 1'b0, v, 8'h06});
    check(user_tx_timing_source, 1'b0);
    cd = 1;
    ubit_source_i.send_zeros(5);
    ubit_source_i.send_sym({1'b1, 7'($urandom)});
    // misaligned start, two whole packets, then a short one cut by a restart
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < (p < 2 ? 96 : 40); i++) begin
        data_sym(i == 0 ? $urandom_range(34, 23) : $urandom_range(10, 2), p == 0 && i == 0);
      end
      if (p < 2) read_words();
    end
    data_sym($urandom_range(34, 23), 1'b1);
    ubit_source_i.rest();
    repeat (4) @(posedge hclk);
    check(ev_q.size(), 32'h0);
    check(rd_q.size(), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
